// *** adcrs_defs.vh ***
// Overview of operation
// R1: three independent slots: three, four, five
// R2: 10-bit result at bits 15:6, read-only
// R3: overrun set when unread result replaced
// R4: read returns overrun, then clears it
// R5: present flag set on every store
// R6: present flag cleared by slot read
// R7: flags read one when set, zero otherwise
// R8: unused bits read zero; all reset zero
`ifndef ADCRS_DEFS_VH
`define ADCRS_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define ADCRS_OFS_SLOT3     8'h00
`define ADCRS_OFS_SLOT4     8'h04
`define ADCRS_OFS_SLOT5     8'h08
`define ADCRS_OFS_INT_STAT  8'h0C
`define ADCRS_OFS_INT_MASK  8'h10

// ****************************************
// slot field layout
// ****************************************
`define ADCRS_VALUE_MSB     15
`define ADCRS_VALUE_LSB     6
`define ADCRS_OVR_BIT       1
`define ADCRS_PRES_BIT      0

// ****************************************
// interrupt field layout
// ****************************************
`define ADCRS_INT_STORE_LSB 0
`define ADCRS_INT_OVR_LSB   3
`define ADCRS_INT_WIDTH     6

// ****************************************
// reset values
// ****************************************
`define ADCRS_RST_VALUE     10'h000
`define ADCRS_RST_INT       6'h00
`define ADCRS_RST_WORD      32'h0000_0000

`endif

// *** adcrs_result_slots.v ***
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "adcrs_defs.vh"

module adcrs_result_slots #(
    parameter ADDR_W  = 8,
    parameter RES_W   = 10,
    parameter N_SLOTS = 3
) (
    // clock and reset
    input  wire                     sys_clk,
    input  wire                     rst_n,
    // register port
    input  wire [ADDR_W-1:0]        regAddr,
    input  wire [31:0]              regWrData,
    input  wire                     regWr,
    input  wire                     regRd,
    output reg  [31:0]              regRdData,
    // conversion engine store port
    input  wire                     storeValid,
    input  wire [1:0]               storeSlot,
    input  wire [RES_W-1:0]         storeValue,
    // slot state for observation
    output wire [N_SLOTS-1:0]       slotPresent,
    output wire [N_SLOTS-1:0]       slotOverrun,
    // interrupt
    output wire                     irq
);

    // ****************************************
    // reset synchroniser
    // ****************************************
    reg rstMeta_r;
    reg rstSync_r;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    wire rstSync_n = rstSync_r;

    // ****************************************
    // address decode
    // ****************************************
    wire [ADDR_W-1:0] ofsSlot3 = `ADCRS_OFS_SLOT3;
    wire [ADDR_W-1:0] ofsSlot4 = `ADCRS_OFS_SLOT4;
    wire [ADDR_W-1:0] ofsSlot5 = `ADCRS_OFS_SLOT5;
    wire [ADDR_W-1:0] ofsStat  = `ADCRS_OFS_INT_STAT;
    wire [ADDR_W-1:0] ofsMask  = `ADCRS_OFS_INT_MASK;

    wire [N_SLOTS-1:0] slotSel;
    assign slotSel[0] = (regAddr == ofsSlot3);
    assign slotSel[1] = (regAddr == ofsSlot4);
    assign slotSel[2] = (regAddr == ofsSlot5);

    wire selStat = (regAddr == ofsStat);
    wire selMask = (regAddr == ofsMask);

    // ****************************************
    // result slots
    // ****************************************
    wire [RES_W-1:0]   slotValue [0:N_SLOTS-1];
    wire [N_SLOTS-1:0] storeEvt;
    wire [N_SLOTS-1:0] ovrEvt;

    genvar g;
    generate
        for (g = 0; g < N_SLOTS; g = g + 1) begin : gSlot
            reg [RES_W-1:0] value_r;
            reg             present_r;
            reg             overrun_r;
            wire            wrHit;
            wire            rdHit;

            // each slot decodes its own store and read
            assign wrHit = storeValid &&
                           ({30'd0, storeSlot} == g); // see R1
            assign rdHit = regRd && slotSel[g];

            always @(posedge sys_clk or negedge rstSync_n) begin
                if (!rstSync_n) begin
                    value_r   <= `ADCRS_RST_VALUE; // see R8
                    present_r <= 1'b0;
                    overrun_r <= 1'b0;
                end else begin
                    if (wrHit) begin
                        value_r <= storeValue; // see R2
                    end
                    // store beats a same-cycle read clear
                    present_r <= wrHit | (present_r & ~rdHit); // see R5 see R6
                    overrun_r <= (wrHit & present_r)
                               | (overrun_r & ~rdHit); // see R3 see R4
                end
            end

            assign slotValue[g]   = value_r;
            assign slotPresent[g] = present_r; // see R7
            assign slotOverrun[g] = overrun_r; // see R7
            assign storeEvt[g]    = wrHit;
            assign ovrEvt[g]      = wrHit & present_r;
        end
    endgenerate

    // ****************************************
    // interrupt status and mask
    // ****************************************
    reg  [`ADCRS_INT_WIDTH-1:0] intStat_r;
    reg  [`ADCRS_INT_WIDTH-1:0] intStat_nxt;
    reg  [`ADCRS_INT_WIDTH-1:0] intMask_r;
    wire [`ADCRS_INT_WIDTH-1:0] intEvt;
    wire [`ADCRS_INT_WIDTH-1:0] intClr;

    assign intEvt = {ovrEvt, storeEvt};
    assign intClr = (regWr && selStat) ?
                    regWrData[`ADCRS_INT_WIDTH-1:0] :
                    `ADCRS_RST_INT;

    always @* begin
        // event wins over write-one-to-clear
        intStat_nxt = intEvt | (intStat_r & ~intClr);
    end

    always @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            intStat_r <= `ADCRS_RST_INT;
            intMask_r <= `ADCRS_RST_INT;
        end else begin
            intStat_r <= intStat_nxt;
            if (regWr && selMask) begin
                intMask_r <= regWrData[`ADCRS_INT_WIDTH-1:0];
            end
        end
    end

    assign irq = |(intStat_r & intMask_r);

    // ****************************************
    // read data
    // ****************************************
    reg [31:0] rdWord;
    integer    k;

    always @* begin
        rdWord = `ADCRS_RST_WORD; // see R8
        for (k = 0; k < N_SLOTS; k = k + 1) begin
            if (slotSel[k]) begin
                rdWord[`ADCRS_VALUE_MSB:`ADCRS_VALUE_LSB] = slotValue[k]; // see R2
                rdWord[`ADCRS_OVR_BIT]  = slotOverrun[k]; // see R4
                rdWord[`ADCRS_PRES_BIT] = slotPresent[k]; // see R7
            end
        end
        if (selStat) begin
            rdWord[`ADCRS_INT_WIDTH-1:0] = intStat_r;
        end
        if (selMask) begin
            rdWord[`ADCRS_INT_WIDTH-1:0] = intMask_r;
        end
    end

    // data stands only in the cycle after the read strobe
    always @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            regRdData <= `ADCRS_RST_WORD;
        end else if (regRd) begin
            regRdData <= rdWord;
        end else begin
            regRdData <= `ADCRS_RST_WORD;
        end
    end

endmodule // adcrs_result_slots

`default_nettype wire

// *** adcrs_result_slots_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module adcrs_checker (
    // watched ports
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  regAddr,
    input wire logic        regRd,
    input wire logic [31:0] regRdData,
    input wire logic        storeValid,
    input wire logic [1:0]  storeSlot,
    input wire logic [2:0]  slotPresent,
    input wire logic [2:0]  slotOverrun
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic       stS = storeValid && storeSlot != 2'b11;
    wire logic       rdS = regRd && regAddr < 8'h0c && regAddr[1:0] == 2'b00;
    wire logic [1:0] rS  = regAddr[3:2];
    property p_pres_set; stS |=> slotPresent[$past(storeSlot)]; endproperty
    a_pres_set: assert property (p_pres_set) else $error("present");
    property p_ovr_set;
        stS && slotPresent[storeSlot] |=> slotOverrun[$past(storeSlot)];
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun");
    property p_ovr_cause; (slotOverrun & ~$past(slotOverrun)) != 3'b000 |->
        $past(stS); endproperty
    a_ovr_cause: assert property (p_ovr_cause) else $error("cause");
    property p_rd_clr; rdS && !(stS && storeSlot == rS) |=>
        !slotPresent[$past(rS)] && !slotOverrun[$past(rS)]; endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("clear");
    property p_rd_flags; rdS |=> regRdData[1:0] ==
        $past({slotOverrun[rS], slotPresent[rS]}); endproperty
    a_rd_flags: assert property (p_rd_flags) else $error("flags");
    property p_rd_zero; rdS |=> regRdData[31:16] == 16'h0000 &&
        regRdData[5:2] == 4'h0; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unused");
    property p_rd_idle; !regRd |=> regRdData == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("idle");
    property p_hold; !stS && !rdS |=>
        $stable(slotPresent) && $stable(slotOverrun); endproperty
    a_hold: assert property (p_hold) else $error("hold");
endmodule // adcrs_checker
bind adcrs_result_slots adcrs_checker chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData),
    .storeValid(storeValid), .storeSlot(storeSlot),
    .slotPresent(slotPresent), .slotOverrun(slotOverrun));
`default_nettype wire

// *** adcrs_engine_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module adcrs_engine_model (
    // store port
    input  wire logic       sys_clk,
    output var  logic       storeValid = 1'b0,
    output var  logic [1:0] storeSlot = 2'b00,
    output var  logic [9:0] storeValue = 10'h000
);
    task automatic put(input logic [1:0] s, input logic [9:0] v);
        @(posedge sys_clk);
        storeValid <= 1'b1;
        storeSlot <= s;
        storeValue <= v;
        @(posedge sys_clk);
        storeValid <= 1'b0;
        storeValue <= ~v; // released data does not hold
        #1;
    endtask
endmodule // adcrs_engine_model
`default_nettype wire

// *** test_adc_result_slots_three_to_five.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_adc_result_slots_three_to_five;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    wire  [31:0] regRdData;
    wire         storeValid, irq;
    wire  [1:0]  storeSlot;
    wire  [9:0]  storeValue;
    wire  [2:0]  slotPresent, slotOverrun;
    int          badCount = 0;
    int          checks = 0;
    adcrs_result_slots adcrs_result_slots_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .storeValid(storeValid), .storeSlot(storeSlot),
        .storeValue(storeValue), .slotPresent(slotPresent),
        .slotOverrun(slotOverrun), .irq(irq));
    adcrs_engine_model eng_i (.sys_clk(sys_clk), .storeValid(storeValid),
        .storeSlot(storeSlot), .storeValue(storeValue));
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            badCount++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWr <= w;
        regRd <= !w;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0000_0000);
        chk("regRdData", e, regRdData);
    endtask
    task automatic summarize;
        if (badCount == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int k = 0; k < 6; k++) rd(8'(4 * k), 32'h0000_0000);
        for (int k = 0; k < 3; k++) eng_i.put(2'(k), 10'(k * 300 + 17));
        eng_i.put(2'b11, 10'h3ff);
        chk("slotPresent", 32'h0000_0007, slotPresent);
        for (int k = 0; k < 3; k++)
            rd(8'(4 * k), {16'h0000, 10'(k * 300 + 17), 6'h01});
        for (int k = 0; k < 3; k++)
            rd(8'(4 * k), {16'h0000, 10'(k * 300 + 17), 6'h00});
        eng_i.put(2'b01, 10'h2aa);
        eng_i.put(2'b01, 10'h155);
        chk("slotOverrun", 32'h0000_0002, slotOverrun);
        acc(1'b1, 8'h04, 32'hffff_ffff);
        rd(8'h04, {16'h0000, 10'h155, 6'h03});
        rd(8'h04, {16'h0000, 10'h155, 6'h00});
        acc(1'b1, 8'h0c, 32'h0000_003f);
        acc(1'b1, 8'h10, 32'h0000_0001);
        chk("irq", 32'h0000_0000, irq);
        eng_i.put(2'b00, 10'h001);
        #1 chk("irq", 32'h0000_0001, irq);
        acc(1'b1, 8'h0c, 32'h0000_0001);
        chk("irq", 32'h0000_0000, irq);
        summarize;
    end
    initial begin
        #20us;
        badCount++;
        summarize;
    end
endmodule // test_adc_result_slots_three_to_five
`default_nettype wire
